//--- design/cfp_config_port.sv
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_config_port
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // Configuration control pins
  input wire logic reprogram_n,
  input wire logic [1:0] mode_sel_in,
  input wire logic init_n_in,
  output cfp_pkg::cfp_drive_type init_n_drv,
  // Status pins
  input wire logic config_busy_high_in,
  output cfp_pkg::cfp_drive_type config_busy_high_out,
  input wire logic config_pending_low_in,
  output cfp_pkg::cfp_drive_type config_pending_low_out,
  // Configuration link
  input wire logic cfg_clock_in,
  output cfp_pkg::cfp_drive_type cfg_clock_drv,
  input wire logic serial_data_in,
  output cfp_pkg::cfp_drive_type serial_data_drv,
  input wire logic [7:0] parallel_cfg_data_in,
  input wire logic chain_select_in,
  // Boundary-scan pins
  input cfp_pkg::cfp_test_type test_pins_in,
  output logic scan_enable,
  output cfp_pkg::cfp_test_type scan_test,
  // User side
  input cfp_pkg::cfp_drive_type [2:0] user_pin_drv,
  output logic [2:0] user_pin_val,
  output cfp_pkg::cfp_test_type user_test_val,
  output logic outputs_active
);
  import cfp_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [19:0] sync1;
  logic [19:0] sync2;
  logic s_prog_n;
  logic [1:0] s_mode;
  logic s_init_n;
  logic s_busy;
  logic s_pend;
  logic s_cfg_clock;
  logic s_din;
  logic [7:0] s_par;
  logic s_csel;
  cfp_test_type s_test;

  // Every pin crosses two flops before use
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1 <= 20'h00000;
      sync2 <= 20'h00000;
    end
    else
    begin
      sync1 <= {reprogram_n, mode_sel_in, init_n_in, config_busy_high_in,
                config_pending_low_in, cfg_clock_in, serial_data_in,
                parallel_cfg_data_in, chain_select_in, test_pins_in};
      sync2 <= sync1;
    end
  end

  // Unpack the synchronised pins
  assign {s_prog_n, s_mode, s_init_n, s_busy, s_pend, s_cfg_clock, s_din,
          s_par, s_csel, s_test} = sync2;

  // ----------------------------------------
  // Registers and sequencer state
  // ----------------------------------------
  cfp_state_type state;
  cfp_mode_type mode;
  logic scan_used;
  logic [15:0] length;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [15:0] count;
  logic extra_clear;
  logic [15:0] byte_count;
  logic [7:0] last_byte;
  logic [6:0] shift;
  logic [2:0] bit_count;
  logic cfg_clock_d;
  logic m_clk;
  logic [15:0] div_count;
  logic [1:0] fwd;
  logic bus_req;
  logic bus_take;
  logic rise;
  logic fall;
  logic byte_valid;
  logic [7:0] next_byte;
  logic ev_done;
  logic ev_fault;
  logic is_master;

  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;
  assign is_master = (mode == mode_master);

  // ----------------------------------------
  // Configuration clock edges
  // ----------------------------------------
  // Slave edges come from the sampled pin, master edges from the divider
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_clock_d <= 1'b0;
    else
      cfg_clock_d <= s_cfg_clock;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      m_clk <= 1'b0;
      div_count <= 16'h0000;
    end
    else if (state == st_load && is_master)
    begin
      if (div_count == `CFP_CFG_CLOCK_HALF - 16'h0001)
      begin
        div_count <= 16'h0000;
        m_clk <= ~m_clk;
      end
      else
        div_count <= div_count + 16'h0001;
    end
    else
    begin
      m_clk <= 1'b0;
      div_count <= 16'h0000;
    end
  end

  // Edge pulses seen by the load logic
  always_comb
  begin
    if (is_master)
    begin
      rise = (state == st_load) && (div_count == `CFP_CFG_CLOCK_HALF - 16'h0001) && !m_clk;
      fall = (state == st_load) && (div_count == `CFP_CFG_CLOCK_HALF - 16'h0001) && m_clk;
    end
    else
    begin
      rise = s_cfg_clock & ~cfg_clock_d;
      fall = ~s_cfg_clock & cfg_clock_d;
    end
  end

  // ----------------------------------------
  // Data capture
  // ----------------------------------------
  // bit and byte capture
  always_comb
  begin
    byte_valid = 1'b0;
    next_byte = 8'h00;
    if (state == st_load && rise)
    begin
      if (mode == mode_parallel)
      begin
        byte_valid = s_csel;
        next_byte = s_par;
      end
      else
      begin
        byte_valid = (bit_count == 3'h7);
        next_byte = {shift, s_din};
      end
    end
  end

  // Serial shift register, MSB first
  always_ff @(posedge clk)
  begin
    if (!rst_n || state != st_load)
    begin
      shift <= 7'h00;
      bit_count <= 3'h0;
    end
    else if (rise && mode != mode_parallel)
    begin
      shift <= {shift[5:0], s_din};
      bit_count <= bit_count + 3'h1;
    end
  end

  // two-stage pipe so each bit leaves on the second fall
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fwd <= 2'h0;
      serial_data_drv <= '{o: 1'b0, oe: 1'b0};
    end
    else
    begin
      if (rise)
        fwd <= {fwd[0], s_din};
      if (state == st_load && mode != mode_parallel)
      begin
        serial_data_drv.oe <= 1'b1;
        if (fall)
          serial_data_drv.o <= fwd[1];
      end
      else
        serial_data_drv <= '{o: 1'b0, oe: 1'b0};
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign ev_fault = byte_valid && byte_count == 16'h0000 && next_byte != `CFP_SYNC_BYTE;
  assign ev_done = byte_valid && !ev_fault && byte_count + 16'h0001 >= length;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= st_power;
      count <= 16'h0000;
      extra_clear <= 1'b0;
      mode <= mode_slave;
      byte_count <= 16'h0000;
      last_byte <= 8'h00;
    end
    else if (!s_prog_n && state != st_clear)
    begin
      state <= st_clear;
      count <= 16'h0000;
      extra_clear <= 1'b1;
    end
    else
    begin
      case (state)
        st_power:
        begin
          count <= count + 16'h0001;
          if (count == `CFP_POWER_CYCLES)
          begin
            state <= st_clear;
            count <= 16'h0000;
          end
        end
        st_clear:
        begin
          count <= count + 16'h0001;
          if (!s_prog_n)
            extra_clear <= 1'b1;
          // finish this clear, then one more
          if (count == `CFP_CLEAR_CYCLES)
          begin
            count <= 16'h0000;
            if (s_prog_n && extra_clear)
              extra_clear <= 1'b0;
            else if (s_prog_n)
              state <= st_wait;
          end
        end
        // held while init low, mode taken on release
        st_wait:
        begin
          byte_count <= 16'h0000;
          if (s_init_n)
          begin
            mode <= cfp_mode_type'(s_mode);
            count <= 16'h0000;
            state <= (s_mode == mode_master) ? st_delay : st_load;
          end
        end
        // master waits the minimum extra time
        st_delay:
        begin
          count <= count + 16'h0001;
          if (count == 16'(`CFP_WAIT_CYCLES - 1))
            state <= st_load;
        end
        st_load:
        begin
          if (byte_valid)
          begin
            last_byte <= next_byte;
            byte_count <= byte_count + 16'h0001;
          end
          // bad sync byte is a data error
          if (ev_fault)
            state <= st_fault;
          else if (ev_done)
            state <= st_active;
        end
        st_fault:
          state <= st_fault;
        st_active:
          state <= st_active;
        default:
          state <= st_power;
      endcase
    end
  end

  // ----------------------------------------
  // Pin roles
  // ----------------------------------------
  // the user-role handover keys off the one active state; init is pulled low in power, clear and fault
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      config_busy_high_out <= '{o: 1'b1, oe: 1'b1};
      config_pending_low_out <= '{o: 1'b0, oe: 1'b1};
      init_n_drv <= '{o: 1'b0, oe: 1'b1};
      outputs_active <= 1'b0;
    end
    else if (state == st_active)
    begin
      // status pins handed to the user
      config_busy_high_out <= user_pin_drv[0];
      config_pending_low_out <= user_pin_drv[1];
      init_n_drv <= user_pin_drv[2];
      outputs_active <= 1'b1;
    end
    else
    begin
      config_busy_high_out <= '{o: 1'b1, oe: 1'b1};
      config_pending_low_out <= '{o: 1'b0, oe: 1'b1};
      // open drain: only ever pulls low
      init_n_drv.o <= 1'b0;
      init_n_drv.oe <= (state == st_power) || (state == st_clear) || (state == st_fault);
      outputs_active <= 1'b0;
    end
  end

  // Master clock pin, input otherwise
  // Pin takes the divider's next level, so it moves on the edge that samples and forwards
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_clock_drv <= '{o: 1'b0, oe: 1'b0};
    else
      cfg_clock_drv <= '{o: m_clk ^ (is_master & (rise | fall)), oe: (state == st_load) && is_master};
  end

  // Pin levels read back by user logic once active
  always_ff @(posedge clk)
  begin
    if (!rst_n || state != st_active)
      user_pin_val <= 3'h0;
    else
      user_pin_val <= {s_init_n, s_pend, s_busy};
  end

  // ----------------------------------------
  // Boundary scan
  // ----------------------------------------
  // scan lives on only if used
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scan_enable <= 1'b1;
      scan_test <= '{tdi: 1'b0, tck: 1'b0, tms: 1'b0};
      user_test_val <= '{tdi: 1'b0, tck: 1'b0, tms: 1'b0};
    end
    else
    begin
      scan_enable <= (state != st_active) || scan_used;
      if ((state != st_active) || scan_used)
        scan_test <= s_test;
      else
        scan_test <= '{tdi: 1'b0, tck: 1'b0, tms: 1'b0};
      if (state == st_active)
        user_test_val <= s_test;
      else
        user_test_val <= '{tdi: 1'b0, tck: 1'b0, tms: 1'b0};
    end
  end

  // ----------------------------------------
  // Avalon slave
  // ----------------------------------------
  // One wait cycle, then a one-cycle acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
  end

  // Writes land on the acknowledge edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scan_used <= `CFP_CTRL_RESET;
      length <= `CFP_LENGTH_RESET;
      irq_mask <= `CFP_IRQ_RESET;
    end
    else if (bus_take && avs_write)
    begin
      case (avs_address)
        `CFP_ADDR_CTRL: scan_used <= avs_writedata[`CFP_CTRL_SCAN_BIT];
        `CFP_ADDR_LENGTH: length <= avs_writedata[15:0];
        `CFP_ADDR_IRQ_MASK: irq_mask <= avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_stat <= `CFP_IRQ_RESET;
    else
    begin
      if (bus_take && avs_write && avs_address == `CFP_ADDR_IRQ_STAT)
        irq_stat <= irq_stat & ~avs_writedata[2:0] | {byte_valid, ev_fault, ev_done};
      else
        irq_stat <= irq_stat | {byte_valid, ev_fault, ev_done};
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // Read data set up while waitrequest is still high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read && avs_waitrequest)
    begin
      case (avs_address)
        `CFP_ADDR_CTRL: avs_readdata <= {31'h00000000, scan_used};
        `CFP_ADDR_LENGTH: avs_readdata <= {16'h0000, length};
        `CFP_ADDR_STATUS: avs_readdata <= {19'h00000, outputs_active, 2'h0, mode, 1'b0, state};
        `CFP_ADDR_IRQ_STAT: avs_readdata <= {29'h00000000, irq_stat};
        `CFP_ADDR_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask};
        `CFP_ADDR_PROGRESS: avs_readdata <= {8'h00, last_byte, byte_count};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule // cfp_config_port

//--- design/cfp_regs.svh
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH
// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define CFP_ADDR_CTRL 3'h0
`define CFP_ADDR_LENGTH 3'h1
`define CFP_ADDR_STATUS 3'h2
`define CFP_ADDR_IRQ_STAT 3'h3
`define CFP_ADDR_IRQ_MASK 3'h4
`define CFP_ADDR_PROGRESS 3'h5
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CFP_CTRL_SCAN_BIT 0
`define CFP_CTRL_RESET 1'h0
`define CFP_LENGTH_RESET 16'h0010
`define CFP_IRQ_DONE_BIT 0
`define CFP_IRQ_FAULT_BIT 1
`define CFP_IRQ_BYTE_BIT 2
`define CFP_IRQ_RESET 3'h0
`define CFP_SYNC_BYTE 8'ha5
// ----------------------------------------
// Timing
// ----------------------------------------
`define CFP_CLK_MHZ 25
`define CFP_WAIT_MIN_US 30
`define CFP_WAIT_MAX_US 300
`define CFP_WAIT_CYCLES (`CFP_WAIT_MIN_US * `CFP_CLK_MHZ)
`define CFP_POWER_CYCLES 16'h0010
`define CFP_CLEAR_CYCLES 16'h0040
`define CFP_CFG_CLOCK_HALF 16'h0004
`endif

//--- design/cfp_pkg.sv
package cfp_pkg;
  // One-hot sequencer states
  typedef enum logic [6:0]
  {
    st_power = 7'h01,
    st_clear = 7'h02,
    st_wait = 7'h04,
    st_delay = 7'h08,
    st_load = 7'h10,
    st_fault = 7'h20,
    st_active = 7'h40
  } cfp_state_type;
  // Configuration modes from the mode pins
  typedef enum logic [1:0]
  {
    mode_master = 2'h0,
    mode_slave = 2'h1,
    mode_parallel = 2'h2,
    mode_slave_alt = 2'h3
  } cfp_mode_type;
  // Output level and output enable of one pin
  typedef struct packed
  {
    logic o;
    logic oe;
  } cfp_drive_type;
  // Boundary-scan input pins
  typedef struct packed
  {
    logic tdi;
    logic tck;
    logic tms;
  } cfp_test_type;
endpackage

//--- verif/cfp_config_port_assertions.sv
`timescale 1ns/1ns
`include "cfp_regs.svh"
module cfp_port_checker
(
  // Clock, reset, bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Pins
  input wire logic [1:0] mode_sel_in,
  input wire logic init_n_in,
  input wire logic cfg_clock_in,
  input cfp_pkg::cfp_drive_type init_n_drv,
  input cfp_pkg::cfp_drive_type config_busy_high_out,
  input cfp_pkg::cfp_drive_type config_pending_low_out,
  input cfp_pkg::cfp_drive_type cfg_clock_drv,
  input cfp_pkg::cfp_drive_type serial_data_drv,
  // Scan and user side
  input wire logic scan_enable,
  input cfp_pkg::cfp_test_type scan_test,
  input cfp_pkg::cfp_drive_type [2:0] user_pin_drv,
  input cfp_pkg::cfp_test_type user_test_val,
  input wire logic outputs_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  localparam int WAIT_LO = `CFP_WAIT_CYCLES;
  // Slack of eight covers the pin synchroniser
  localparam int WAIT_HI = `CFP_WAIT_MAX_US * `CFP_CLK_MHZ + 8;
  logic [13:0] high_cnt;
  // Cycles the init line has stayed high, saturating
  always_ff @(posedge clk)
  begin
    if (!rst_n || !init_n_in)
      high_cnt <= 14'h0;
    else if (high_cnt != 14'h3fff)
      high_cnt <= high_cnt + 14'h1;
  end
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus access not answered");
  property p_busy;
    !outputs_active |-> config_busy_high_out == 2'b11;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not driven high");
  property p_pend;
    !outputs_active |-> config_pending_low_out == 2'b01;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not driven low");
  property p_power;
    $rose(rst_n) |-> (init_n_drv == 2'b01) [*8];
  endproperty
  a_power: assert property (p_power) else $error("init not low at power-up");
  property p_delay;
    $rose(cfg_clock_drv.oe) |-> high_cnt >= WAIT_LO && high_cnt <= WAIT_HI;
  endproperty
  a_delay: assert property (p_delay) else $error("master wait out of range");
  property p_roles;
    outputs_active && $past(outputs_active) |->
      {init_n_drv, config_pending_low_out, config_busy_high_out} == $past(user_pin_drv);
  endproperty
  a_roles: assert property (p_roles) else $error("pins not in user role");
  property p_slave;
    mode_sel_in != 2'h0 |-> !cfg_clock_drv.oe;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock");
  property p_fwd;
    serial_data_drv.oe && $past(serial_data_drv.oe) && $changed(serial_data_drv.o)
      |-> !cfg_clock_in && ($past(cfg_clock_in) || $past(cfg_clock_in, 4));
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded bit off falling edge");
  property p_scan;
    !outputs_active && !$past(outputs_active) |-> scan_enable && user_test_val == 3'h0;
  endproperty
  a_scan: assert property (p_scan) else $error("scan state wrong in config");
  property p_scan_off;
    !scan_enable && !$past(scan_enable) |-> scan_test == 3'h0;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("scan pins leak");
  // Main scenarios reached
  c_active: cover property ($rose(outputs_active));
  c_master: cover property ($rose(cfg_clock_drv.oe));
  c_hold: cover property (!init_n_in && !outputs_active ##1 init_n_in);
endmodule // cfp_port_checker

bind cfp_config_port cfp_port_checker chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mode_sel_in(mode_sel_in),
  .init_n_in(init_n_in), .cfg_clock_in(cfg_clock_in), .init_n_drv(init_n_drv),
  .config_busy_high_out(config_busy_high_out), .cfg_clock_drv(cfg_clock_drv),
  .config_pending_low_out(config_pending_low_out), .serial_data_drv(serial_data_drv),
  .scan_enable(scan_enable), .scan_test(scan_test), .user_pin_drv(user_pin_drv),
  .user_test_val(user_test_val), .outputs_active(outputs_active));

//--- verif/cfp_source_model.sv
`timescale 1ns/1ns
module cfp_source_model
(
  // Resolved clock line
  input wire logic clock_line,
  // Toward the device
  output logic src_clock,
  output logic src_data,
  output logic [7:0] src_byte,
  output logic src_select
);
  // Clock rests low outside frames
  initial
  begin
    src_clock = 1'b0;
    src_data = 1'b1;
    src_byte = 8'hff;
    src_select = 1'b0;
  end
  task automatic send_serial(input logic [7:0] b, input logic master, input logic last);
    for (int i = 7; i >= 0; i--)
    begin
      src_data = b[i];
      if (master)
      begin
        @(posedge clock_line);
        if (!(last && i == 0))
          @(negedge clock_line);
      end
      else
      begin
        #160 src_clock = 1'b1;
        #160 src_clock = 1'b0;
      end
    end
  endtask
  task automatic send_par(input logic [7:0] b, input logic sel);
    src_byte = b;
    src_select = sel;
    #160 src_clock = 1'b1;
    #160 src_clock = 1'b0;
    src_byte = ~b;
  endtask
  // Released lines must not keep the old value
  task automatic release_lines();
    src_data = ~src_data;
    src_select = 1'b0;
  endtask
endmodule // cfp_source_model

//--- verif/cfp_config_port_tb_top.sv
`timescale 1ns/1ns
`include "cfp_regs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module cfp_config_port_tb_top;
  import cfp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq, scan_enable, outputs_active;
  logic reprogram_n = 1'b1;
  logic [1:0] mode_sel_in = 2'h1;
  logic init_hold_n = 1'b0;
  cfp_drive_type init_n_drv, busy_drv, pend_drv, clk_drv, sdo_drv;
  cfp_drive_type [2:0] user_pin_drv = 6'b00_11_01;
  cfp_test_type test_pins_in = 3'b101;
  cfp_test_type scan_test, user_test_val;
  logic [2:0] user_pin_val;
  logic init_line, cfg_line, src_clock, src_data, src_select;
  logic [7:0] src_byte;
  logic [1:0] hist = 2'h0;
  int errors = 0, n_compared = 0, cycles = 0, rises = 0;
  // Open-drain init with pull-up; bench may hold it low
  assign init_line = init_hold_n && !(init_n_drv.oe && !init_n_drv.o);
  assign cfg_line = clk_drv.oe ? clk_drv.o : src_clock;
  always #20 clk = ~clk;
  cfp_config_port dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .reprogram_n(reprogram_n), .mode_sel_in(mode_sel_in), .init_n_in(init_line),
    .init_n_drv(init_n_drv), .config_busy_high_in(busy_drv.oe ? busy_drv.o : 1'b1),
    .config_busy_high_out(busy_drv), .config_pending_low_out(pend_drv),
    .config_pending_low_in(pend_drv.oe ? pend_drv.o : 1'b1), .cfg_clock_in(cfg_line),
    .cfg_clock_drv(clk_drv), .serial_data_in(src_data), .serial_data_drv(sdo_drv),
    .parallel_cfg_data_in(src_byte), .chain_select_in(src_select),
    .test_pins_in(test_pins_in), .scan_enable(scan_enable), .scan_test(scan_test),
    .user_pin_drv(user_pin_drv), .user_pin_val(user_pin_val),
    .user_test_val(user_test_val), .outputs_active(outputs_active));
  cfp_source_model src (.clock_line(cfg_line), .src_clock(src_clock),
    .src_data(src_data), .src_byte(src_byte), .src_select(src_select));
  // Forwarded bit lags the input by two rises
  always @(posedge cfg_line)
  begin
    if (sdo_drv.oe === 1'b1 && rises >= 2)
      `CHK(sdo_drv.o, hist[1]);
    hist <= {hist[0], src_data};
    rises <= rises + 1;
  end
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Reprogram pulse; returns once init is released
  task automatic restart(input logic [1:0] m);
    int k;
    k = 0;
    @(posedge clk);
    reprogram_n <= 1'b0;
    mode_sel_in <= m;
    repeat (10) @(posedge clk);
    `CHK(init_n_drv, 2'b01);
    reprogram_n <= 1'b1;
    while (init_line !== 1'b1)
    begin
      @(posedge clk);
      k++;
    end
    `CHK(k >= 65, 1'b1);
    rises = 0;
  endtask
  task automatic t_wait();
    `CHK(busy_drv, 2'b11);
    `CHK(pend_drv, 2'b01);
    `CHK(init_n_drv, 2'b01);
    bus(1'b0, `CFP_ADDR_LENGTH, 32'h0);
    `CHK(q, `CFP_LENGTH_RESET);
    bus(1'b1, 3'h7, 32'hffff_ffff);
    bus(1'b0, 3'h7, 32'h0);
    `CHK(q, 32'h0);
    repeat (300) @(posedge clk);
    bus(1'b0, `CFP_ADDR_STATUS, 32'h0);
    `CHK(q[6:0], st_wait);
    init_hold_n <= 1'b1;
    repeat (20) @(posedge clk);
    bus(1'b0, `CFP_ADDR_STATUS, 32'h0);
    `CHK(q[9:0], {2'h1, 1'b0, st_load});
    $display("wait test done");
  endtask
  task automatic t_serial();
    @(posedge clk);
    #7;
    for (int n = 0; n < 16; n++)
      src.send_serial(n == 0 ? `CFP_SYNC_BYTE : 8'(n * 17), 1'b0, 1'b0);
    src.release_lines();
    repeat (10) @(posedge clk);
    `CHK(outputs_active, 1'b1);
    `CHK({init_n_drv, pend_drv, busy_drv}, user_pin_drv);
    `CHK(user_pin_val, 3'b110);
    `CHK({scan_enable, scan_test}, 4'h0);
    `CHK(user_test_val, test_pins_in);
    bus(1'b0, `CFP_ADDR_PROGRESS, 32'h0);
    `CHK(q[23:0], 24'hff0010);
    `CHK(irq, 1'b0);
    bus(1'b1, `CFP_ADDR_IRQ_MASK, 32'h1);
    bus(1'b0, `CFP_ADDR_IRQ_STAT, 32'h0);
    `CHK(q[2:0], 3'h5);
    `CHK(irq, 1'b1);
    bus(1'b1, `CFP_ADDR_IRQ_STAT, 32'h5);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0);
    $display("serial test done");
  endtask
  task automatic t_parallel();
    restart(2'h2);
    @(posedge clk);
    #7;
    src.send_par(8'h3c, 1'b0);
    src.send_par(`CFP_SYNC_BYTE, 1'b1);
    src.send_par(8'h5a, 1'b1);
    bus(1'b0, `CFP_ADDR_PROGRESS, 32'h0);
    `CHK(q[23:0], 24'h5a0002);
    restart(2'h2);
    @(posedge clk);
    #7;
    src.send_par(`CFP_SYNC_BYTE, 1'b0);
    src.send_par(8'h3c, 1'b1);
    repeat (4) @(posedge clk);
    `CHK(init_n_drv, 2'b01);
    bus(1'b0, `CFP_ADDR_STATUS, 32'h0);
    `CHK(q[6:0], st_fault);
    $display("parallel test done");
  endtask
  task automatic t_master();
    int k;
    k = 0;
    restart(2'h0);
    fork
      while (clk_drv.oe !== 1'b1)
      begin
        @(posedge clk);
        k++;
      end
      for (int n = 0; n < 16; n++)
        src.send_serial(n == 0 ? `CFP_SYNC_BYTE : 8'(n), 1'b1, n == 15);
    join
    src.release_lines();
    `CHK(k >= `CFP_WAIT_CYCLES && k <= 7500, 1'b1);
    repeat (10) @(posedge clk);
    `CHK(outputs_active, 1'b1);
    $display("master test done");
  endtask
  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset for ten cycles, then the scenarios in order
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_wait();
    t_serial();
    t_parallel();
    t_master();
    wrap_up();
  end
endmodule // cfp_config_port_tb_top
